// [inc/nres_pkg.sv]
// Constants shared by both ends of the NVM row erase and program sequencer.
// Assumes a single system clock at CLK_MHZ on both ends.
package nres_pkg;
   // --------------------------------------------------
   // Widths and control register layout
   // --------------------------------------------------
   localparam int ADR_W     = 24;
   localparam int DAT_W     = 16;
   localparam int CNT_W     = 16;
   localparam int ROW_AW    = 5;
   localparam int EE_AW_DEF = 8;
   localparam int OP_LSB    = 0;
   localparam int OP_W      = 6;
   localparam int ERASE_BIT = 6;
   localparam int NV_WRITE_ENABLE_BIT  = 14;
   localparam int WR_BIT    = 15;
   localparam logic REG_CTL = 1'b0;
   localparam logic REG_KEY = 1'b1;
   localparam logic [7:0] KEY1 = 8'h55;
   localparam logic [7:0] KEY2 = 8'hAA;
   // --------------------------------------------------
   // Operation codes
   // --------------------------------------------------
   localparam logic [5:0] OP_ROW_ERASE = 6'h18;
   localparam logic [5:0] OP_ROW_PROG  = 6'h04;
   localparam logic [5:0] OP_EE_ERASE1 = 6'h18;
   localparam logic [5:0] OP_EE_ERASE4 = 6'h19;
   localparam logic [5:0] OP_EE_ERASE8 = 6'h1A;
   localparam logic [5:0] OP_EE_BULK   = 6'h1F;
   localparam logic [5:0] OP_EE_WRITE1 = 6'h04;
   localparam logic [ADR_W-1:0] EE_BASE = 24'h7F_FE00;
   localparam logic [DAT_W-1:0] ERASED  = 16'hFFFF;
   // --------------------------------------------------
   // Timing
   // --------------------------------------------------
   localparam int CLK_MHZ       = 125;
   localparam int ERASE_TIME_NS = 2000;
   localparam int PROG_TIME_NS  = 2000;
   localparam int ERASE_CYC_DEF = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_CYC_DEF  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
   // --------------------------------------------------
   // Controller registers on Wishbone
   // --------------------------------------------------
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_ADDR = 8'h04;
   localparam logic [7:0] WB_DATA = 8'h08;
   localparam logic [7:0] WB_STAT = 8'h0C;
   localparam int H_KIND_LSB = 8;
   localparam int H_GO_BIT   = 15;
   localparam logic [9:0] H_CTL_MASK = 10'h37F;
   localparam logic [1:0] KIND_LATCH = 2'h0;
   localparam logic [1:0] KIND_OP    = 2'h1;
   localparam logic [1:0] KIND_READ  = 2'h2;
endpackage

// [inc/nres_if.sv]
// Link between the core-side controller and the NVM sequencer.
// Both ends run on the same sys_clk; all strobes are one-cycle pulses.
`timescale 1ns/100ps
interface nres_if;
   logic        regWr;
   logic        regSel;
   logic [15:0] regWdata;
   logic [15:0] ctlRd;
   logic        tblWr;
   logic        tblHigh;
   logic        tblRd;
   logic [23:0] tblAddr;
   logic [15:0] tblWdata;
   logic [15:0] tblRdata;
   logic        stall;
   modport dev (input regWr, regSel, regWdata, tblWr, tblHigh, tblRd, tblAddr, tblWdata,
                output ctlRd, tblRdata, stall);
   modport core (output regWr, regSel, regWdata, tblWr, tblHigh, tblRd, tblAddr, tblWdata,
                 input ctlRd, tblRdata, stall);
endinterface

// [rtl/nres_device.sv]
// NVM row erase and program sequencer with data EEPROM array.
// Assumes the core side honours stall and issues one access per cycle.
//
// What this block does
// - Software edits whole 32-instruction rows in RAM
// - Operation code 011000 selects row erase
// - Erase bit 6, write-enable bit 14
// - Start bit 15 begins cycle, core stalls
// - Hardware clears start bit at end
// - Code 000100, erase clear: row program
// - No operation without the unlock sequence
// - Two idle slots after the start write
// - Unlock and start run uninterrupted
// - Dummy table write sets erase address
// - Row buffers loaded before programming
// - Address captured from last table write
// - Upper holds 8 bits, lower 16
// - Address only loadable by table writes
// - Address least bit forced to zero
// - Upper address top bit reads zero
// - EEPROM is 16 bits, high writes ignored
// - EEPROM erase of one, four, eight words
// - EEPROM bulk erase, word write, word read
// - No EEPROM read during an operation; the read port still answers tblRd while busy
`timescale 1ns/100ps
module nres_device
   import nres_pkg::*;
#(
   parameter int EE_AW     = EE_AW_DEF,
   parameter int ERASE_CYC = ERASE_CYC_DEF,
   parameter int PROG_CYC  = PROG_CYC_DEF
) (
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   nres_if.dev                     io,
   output logic                    fmErase,
   output logic                    fmProg,
   output logic [ADR_W-1:0]        fmAddr,
   output logic                    fmLatchWe,
   output logic                    fmLatchHigh,
   output logic [ROW_AW-1:0]       fmLatchIdx,
   output logic [DAT_W-1:0]        fmLatchData
);
   typedef enum logic [1:0] {KEY_IDLE, KEY_55, KEY_ARMED} nres_key_e;

   // --------------------------------------------------
   // State
   // --------------------------------------------------
   nres_key_e              key_r;
   logic [OP_W-1:0]        op_r;
   logic                   erase_r;
   logic                   nv_write_enable_r;
   logic                   wr_r;
   logic                   busy_r;
   logic [CNT_W-1:0]       cnt_r;
   logic [7:0]             adrU_r;
   logic [15:0]            adrL_r;
   logic [DAT_W-1:0]       eeLatch_r;
   logic [DAT_W-1:0]       rdData_r;
   logic [DAT_W-1:0]       ee_r [2**EE_AW];

   // --------------------------------------------------
   // Decode
   // --------------------------------------------------
   wire logic [ADR_W-1:0]  tAddr   = {1'b0, io.tblAddr[ADR_W-2:1], 1'b0};
   wire logic              tblEe   = tAddr[ADR_W-1:EE_AW+1] == EE_BASE[ADR_W-1:EE_AW+1];
   wire logic [ADR_W-1:0]  capAddr = {adrU_r, adrL_r};
   wire logic              capEe   = capAddr[ADR_W-1:EE_AW+1] == EE_BASE[ADR_W-1:EE_AW+1];
   wire logic [EE_AW-1:0]  capIdx  = adrL_r[EE_AW:1];
   wire logic [EE_AW-1:0]  rdIdx   = tAddr[EE_AW:1];
   wire logic              ctlWr   = io.regWr & (io.regSel == REG_CTL);
   wire logic              keyWr   = io.regWr & (io.regSel == REG_KEY);
   wire logic [OP_W-1:0]   wOp     = io.regWdata[OP_LSB +: OP_W];
   wire logic              wErase  = io.regWdata[ERASE_BIT];
   wire logic              wWren   = io.regWdata[NV_WRITE_ENABLE_BIT];
   wire logic              wGo     = io.regWdata[WR_BIT];
   wire logic              flashOk = (wOp == OP_ROW_ERASE & wErase)
                                   | (wOp == OP_ROW_PROG & ~wErase);
   wire logic              eeOk    = (wOp inside {OP_EE_ERASE1, OP_EE_ERASE4, OP_EE_ERASE8})
                                   & wErase
                                   | (wOp == OP_EE_WRITE1 & ~wErase);
   wire logic              bulkOk  = (wOp == OP_EE_BULK) & wErase;
   wire logic              opOk    = (capEe ? eeOk : flashOk) | bulkOk;
   wire logic              startOk = ctlWr & wGo & wWren & opOk & ~busy_r
                                   & (key_r == KEY_ARMED);
   wire logic              isProg  = (wOp == OP_ROW_PROG) & ~bulkOk;
   wire logic              lastCyc = busy_r & (cnt_r == '0);

   assign io.stall    = busy_r;
   assign io.ctlRd    = {wr_r, nv_write_enable_r, 7'h00, erase_r, op_r};
   assign io.tblRdata = rdData_r;
   assign fmAddr      = capAddr;

   // --------------------------------------------------
   // Unlock key sequence
   // --------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         key_r <= KEY_IDLE;
      end else if (keyWr) begin
         if (io.regWdata[7:0] == KEY1) begin
            key_r <= KEY_55;
         end else if (io.regWdata[7:0] == KEY2 && key_r == KEY_55) begin
            key_r <= KEY_ARMED;
         end else begin
            key_r <= KEY_IDLE;
         end
      end else if (ctlWr || io.tblWr || io.tblRd) begin
         key_r <= KEY_IDLE;
      end
   end

   // --------------------------------------------------
   // Control register and operation timer
   // --------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         op_r    <= '0;
         erase_r <= 1'b0;
         nv_write_enable_r  <= 1'b0;
         wr_r    <= 1'b0;
         busy_r  <= 1'b0;
         cnt_r   <= '0;
         fmErase <= 1'b0;
         fmProg  <= 1'b0;
      end else begin
         fmErase <= startOk & ~capEe & ~bulkOk & (wOp == OP_ROW_ERASE);
         fmProg  <= startOk & ~capEe & isProg;
         if (ctlWr && !busy_r) begin
            op_r    <= wOp;
            erase_r <= wErase;
            nv_write_enable_r  <= wWren;
         end
         if (startOk) begin
            wr_r   <= 1'b1;
            busy_r <= 1'b1;
            cnt_r  <= isProg ? CNT_W'(PROG_CYC - 1) : CNT_W'(ERASE_CYC - 1);
         end else if (lastCyc) begin
            wr_r   <= 1'b0;
            busy_r <= 1'b0;
         end else if (busy_r) begin
            cnt_r  <= cnt_r - 1'b1;
         end
      end
   end

   // --------------------------------------------------
   // Table write capture and read port
   // --------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         adrU_r      <= '0;
         adrL_r      <= '0;
         eeLatch_r   <= '0;
         rdData_r    <= '0;
         fmLatchWe   <= 1'b0;
         fmLatchHigh <= 1'b0;
         fmLatchIdx  <= '0;
         fmLatchData <= '0;
      end else begin
         fmLatchWe <= io.tblWr & ~tblEe;
         if (io.tblWr) begin
            adrU_r      <= tAddr[23:16];
            adrL_r      <= tAddr[15:0];
            fmLatchHigh <= io.tblHigh;
            fmLatchIdx  <= tAddr[ROW_AW:1];
            fmLatchData <= io.tblWdata;
         end
         if (io.tblWr && tblEe && !io.tblHigh) begin
            eeLatch_r <= io.tblWdata;
         end
         if (io.tblRd) begin
            rdData_r <= (tblEe && !io.tblHigh) ? ee_r[rdIdx] : '0;
         end
      end
   end

   // --------------------------------------------------
   // EEPROM array
   // --------------------------------------------------
   for (genvar i = 0; i < 2**EE_AW; i++) begin : g_ee
      wire logic [EE_AW-1:0] ix   = EE_AW'(i);
      wire logic             hit1 = ix == capIdx;
      wire logic             hit4 = ix[EE_AW-1:2] == capIdx[EE_AW-1:2];
      wire logic             hit8 = ix[EE_AW-1:3] == capIdx[EE_AW-1:3];
      wire logic             wipe = lastCyc & erase_r
                                  & ((op_r == OP_EE_BULK)
                                  | capEe & ((op_r == OP_EE_ERASE1) & hit1
                                  | (op_r == OP_EE_ERASE4) & hit4
                                  | (op_r == OP_EE_ERASE8) & hit8));
      wire logic             put  = lastCyc & ~erase_r & capEe & hit1
                                  & (op_r == OP_EE_WRITE1);
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            ee_r[i] <= ERASED;
         end else if (wipe) begin
            ee_r[i] <= ERASED;
         end else if (put) begin
            ee_r[i] <= eeLatch_r;
         end
      end
   end
endmodule

// [rtl/nres_host.sv]
// Core-side controller: runs latch, erase/program and read sequences.
// Assumes a classic Wishbone master and the sequencer on the other modport.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module nres_host
   import nres_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   nres_if.core             io
);
   typedef enum logic [3:0] {H_IDLE, H_TBL, H_CON, H_K55, H_KAA, H_GO, H_NOP1, H_NOP2,
                             H_WAIT, H_RD, H_RDW, H_RDC} nres_hst_e;

   nres_hst_e     st_r;
   logic [9:0]    hCtl_r;
   logic [23:0]   hAddr_r;
   logic [16:0]   hData_r;
   logic          done_r;
   logic          refused_r;
   logic          seen_r;
   logic [15:0]   rd_r;

   // --------------------------------------------------
   // Wishbone decode
   // --------------------------------------------------
   wire logic        idle   = st_r == H_IDLE;
   wire logic        wbReq  = wb_cyc_i & wb_stb_i;
   wire logic        wbWr   = wbReq & wb_we_i & wb_ack_o & idle;
   wire logic [31:0] mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] ctlNew = ({22'h0, hCtl_r} & ~mask) | (wb_dat_i & mask);
   wire logic [31:0] adrNew = ({8'h00, hAddr_r} & ~mask) | (wb_dat_i & mask);
   wire logic [31:0] datNew = ({15'h0000, hData_r} & ~mask) | (wb_dat_i & mask);
   wire logic        goReq  = wbWr & (wb_adr_i == WB_CTRL) & wb_sel_i[1] & wb_dat_i[H_GO_BIT];
   wire logic [1:0]  kind   = hCtl_r[H_KIND_LSB +: 2];
   wire logic [1:0]  goKind = ctlNew[H_KIND_LSB +: 2];
   wire logic [15:0] ctlWd  = {1'b0, 1'b1, 7'h00, hCtl_r[ERASE_BIT], hCtl_r[OP_W-1:0]};
   wire logic [15:0] goWd   = ctlWd | (16'h0001 << WR_BIT);
   wire logic [31:0] rdMux  = (wb_adr_i == WB_CTRL) ? {22'h0, hCtl_r}
                            : (wb_adr_i == WB_ADDR) ? {8'h00, hAddr_r}
                            : (wb_adr_i == WB_DATA) ? {15'h0000, hData_r}
                            : (wb_adr_i == WB_STAT) ? {rd_r, 13'h0000, refused_r, done_r, ~idle}
                            : 32'h0000_0000;

   // --------------------------------------------------
   // Wishbone slave
   // --------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         hCtl_r   <= '0;
         hAddr_r  <= '0;
         hData_r  <= '0;
      end else begin
         wb_ack_o <= wbReq & ~wb_ack_o;
         if (wbReq && !wb_ack_o) begin
            wb_dat_o <= rdMux;
         end
         if (wbWr && wb_adr_i == WB_CTRL) begin
            hCtl_r <= ctlNew[9:0] & H_CTL_MASK;
         end
         if (wbWr && wb_adr_i == WB_ADDR) begin
            hAddr_r <= adrNew[23:0];
         end
         if (wbWr && wb_adr_i == WB_DATA) begin
            hData_r <= datNew[16:0];
         end
      end
   end

   // --------------------------------------------------
   // Sequencer
   // --------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r        <= H_IDLE;
         done_r      <= 1'b0;
         refused_r   <= 1'b0;
         seen_r      <= 1'b0;
         rd_r        <= '0;
         io.regWr    <= 1'b0;
         io.regSel   <= REG_CTL;
         io.regWdata <= '0;
         io.tblWr    <= 1'b0;
         io.tblHigh  <= 1'b0;
         io.tblRd    <= 1'b0;
         io.tblAddr  <= '0;
         io.tblWdata <= '0;
      end else begin
         io.regWr <= 1'b0;
         io.tblWr <= 1'b0;
         io.tblRd <= 1'b0;
         case (st_r)
            H_IDLE: begin
               if (goReq) begin
                  done_r    <= 1'b0;
                  refused_r <= 1'b0;
                  seen_r    <= 1'b0;
                  st_r      <= (goKind == KIND_READ) ? H_RD : H_TBL;
               end
            end
            H_TBL: begin
               io.tblWr    <= 1'b1;
               io.tblAddr  <= hAddr_r;
               io.tblWdata <= hData_r[15:0];
               io.tblHigh  <= hData_r[16];
               done_r      <= kind != KIND_OP;
               st_r        <= (kind == KIND_OP) ? H_CON : H_IDLE;
            end
            H_CON: begin
               io.regWr    <= 1'b1;
               io.regSel   <= REG_CTL;
               io.regWdata <= ctlWd;
               st_r        <= H_K55;
            end
            H_K55: begin
               io.regWr    <= 1'b1;
               io.regSel   <= REG_KEY;
               io.regWdata <= {8'h00, KEY1};
               st_r        <= H_KAA;
            end
            H_KAA: begin
               io.regWr    <= 1'b1;
               io.regSel   <= REG_KEY;
               io.regWdata <= {8'h00, KEY2};
               st_r        <= H_GO;
            end
            H_GO: begin
               io.regWr    <= 1'b1;
               io.regSel   <= REG_CTL;
               io.regWdata <= goWd;
               st_r        <= H_NOP1;
            end
            H_NOP1: st_r <= H_NOP2;
            H_NOP2: begin
               seen_r <= io.stall;
               st_r   <= H_WAIT;
            end
            H_WAIT: begin
               if (io.stall) begin
                  seen_r <= 1'b1;
               end else if (!io.ctlRd[WR_BIT]) begin
                  done_r    <= 1'b1;
                  refused_r <= ~seen_r;
                  st_r      <= H_IDLE;
               end
            end
            H_RD: begin
               io.tblRd   <= 1'b1;
               io.tblHigh <= 1'b0;
               io.tblAddr <= hAddr_r;
               st_r       <= H_RDW;
            end
            H_RDW: st_r <= H_RDC;
            H_RDC: begin
               rd_r   <= io.tblRdata;
               done_r <= 1'b1;
               st_r   <= H_IDLE;
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule

// [tb/nres_checker.sv]
// Concurrent checks on the link between the core-side controller and the sequencer.
// Assumes one sys_clk and an active-low asynchronous nrst shared by both ends.
`timescale 1ns/100ps
module nres_checker
   import nres_pkg::*;
#(
   parameter int ERASE_CYC = ERASE_CYC_DEF,
   parameter int PROG_CYC  = PROG_CYC_DEF
) (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        regWr,
   input wire logic        regSel,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] ctlRd,
   input wire logic        tblRd,
   input wire logic [15:0] tblRdata,
   input wire logic        stall
);
   // ------------------------------------------------------------
   // Link decode
   // ------------------------------------------------------------
   logic             key1Wr;
   logic             key2Wr;
   logic             goWr;
   logic             opGood;
   logic             opBad;
   logic [5:0]       opSel;
   logic [CNT_W-1:0] stallCnt_r;
   logic [CNT_W-1:0] stallCnt_nxt;
   assign opSel  = regWdata[5:0];
   assign key1Wr = regWr && regSel == REG_KEY && regWdata[7:0] == KEY1;
   assign key2Wr = regWr && regSel == REG_KEY && regWdata[7:0] == KEY2;
   assign goWr   = regWr && regSel == REG_CTL && regWdata[WR_BIT];
   assign opGood = regWdata[NV_WRITE_ENABLE_BIT] && ((opSel == OP_ROW_ERASE && regWdata[ERASE_BIT])
                   || (opSel == OP_ROW_PROG && !regWdata[ERASE_BIT]));
   assign opBad  = !((opSel inside {OP_EE_ERASE1, OP_EE_ERASE4, OP_EE_ERASE8, OP_EE_BULK}
                   && regWdata[ERASE_BIT]) || (opSel == OP_EE_WRITE1 && !regWdata[ERASE_BIT]));
   assign stallCnt_nxt = stall ? stallCnt_r + 1'b1 : '0;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stallCnt_r <= '0;
      end else begin
         stallCnt_r <= stallCnt_nxt;
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence unlockKeys;
      key1Wr ##1 key2Wr;
   endsequence
   a_start_runs: assert property (
      unlockKeys ##1 (goWr && opGood && !stall) |=> stall && ctlRd[WR_BIT])
      else $error("keyed start did not begin a cycle");
   a_start_keyed: assert property (
      $rose(stall) |-> $past(goWr) && $past(key2Wr, 2) && $past(key1Wr, 3))
      else $error("cycle began without the key sequence");
   a_bad_op_refused: assert property (
      unlockKeys ##1 (goWr && opBad && !stall) |=> !stall)
      else $error("invalid operation began a cycle");
   a_busy_length: assert property (
      $fell(stall) |-> int'(stallCnt_r) == (ctlRd[ERASE_BIT] ? ERASE_CYC : PROG_CYC))
      else $error("stall length wrong");
   a_wr_held: assert property (
      stall |-> ctlRd[WR_BIT])
      else $error("start bit low while busy");
   a_wr_self_clear: assert property (
      $fell(stall) |-> !ctlRd[WR_BIT])
      else $error("start bit not cleared at end");
   a_ctl_kept: assert property (
      regWr && regSel == REG_CTL && !stall && !regWdata[WR_BIT] |=>
      ctlRd[14:0] == {$past(regWdata[14]), 7'h00, $past(regWdata[6:0])})
      else $error("control register not updated");
   a_rdata_hold: assert property (
      !$past(tblRd) |-> $stable(tblRdata))
      else $error("read data changed without a read");
endmodule

// [tb/nvm_row_erase_program_sequencer_tb.sv]
// Self-checking bench for the controller and sequencer pair.
// Drives the controller over classic Wishbone; the checker watches the link.
`timescale 1ns/100ps
module nvm_row_erase_program_sequencer_tb
   import nres_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack;
   logic        fmErase;
   logic        fmProg;
   logic [23:0] fmAddr;
   logic        fmLatchWe;
   logic        fmLatchHigh;
   logic [4:0]  fmLatchIdx;
   logic [15:0] fmLatchData;
   logic [23:0] seenAdr;
   logic [21:0] seenLatch;
   int          nErase = 0;
   int          nProg = 0;
   int          badCount = 0;
   int          comparisons = 0;
   always #4 sys_clk = ~sys_clk;
   nres_if link ();
   nres_device #(.EE_AW(3), .ERASE_CYC(4), .PROG_CYC(4)) nres_device_inst (
      .sys_clk(sys_clk), .nrst(nrst), .io(link), .fmErase(fmErase), .fmProg(fmProg),
      .fmAddr(fmAddr), .fmLatchWe(fmLatchWe), .fmLatchHigh(fmLatchHigh),
      .fmLatchIdx(fmLatchIdx), .fmLatchData(fmLatchData));
   nres_host nres_host_inst (
      .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .io(link));
   nres_checker #(.ERASE_CYC(4), .PROG_CYC(4)) nres_checker_inst (
      .sys_clk(sys_clk), .nrst(nrst), .regWr(link.regWr), .regSel(link.regSel),
      .regWdata(link.regWdata), .ctlRd(link.ctlRd), .tblRd(link.tblRd),
      .tblRdata(link.tblRdata), .stall(link.stall));
   // ------------------------------------------------------------
   // Array-side monitor
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (fmErase === 1'b1) nErase <= nErase + 1;
      if (fmProg === 1'b1) nProg <= nProg + 1;
      if (fmErase === 1'b1 || fmProg === 1'b1) seenAdr <= fmAddr;
      if (fmLatchWe === 1'b1) seenLatch <= {fmLatchHigh, fmLatchIdx, fmLatchData};
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      if (ack !== 1'b1) begin
         badCount++;
         end_of_test();
      end
   endtask
   task automatic run(input logic [23:0] a, input logic [16:0] d, input logic [9:0] c,
                      output logic [31:0] st);
      int n;
      logic [31:0] q;
      wb(1'b1, WB_ADDR, {8'h00, a}, q);
      wb(1'b1, WB_DATA, {15'h0000, d}, q);
      wb(1'b1, WB_CTRL, {16'h0000, 1'b1, 5'h00, c}, q);
      n = 0;
      do begin
         wb(1'b0, WB_STAT, 32'h0000_0000, st);
         n++;
      end while (!(st[1] === 1'b1 && st[0] === 1'b0) && n < 40);
      if (n >= 40) begin
         badCount++;
         end_of_test();
      end
      @(negedge sys_clk);
   endtask
   task automatic eeOp(input logic [23:0] a, input logic [16:0] d, input logic [9:0] c);
      logic [31:0] st;
      run(a, d, c, st);
      check("eeprom status", 32'h0000_0002, {29'h0000_0000, st[2:0]});
   endtask
   task automatic eeRead(input logic [23:0] a, input logic [15:0] exp);
      logic [31:0] st;
      run(a, 17'h0_0000, 10'h200, st);
      check("eeprom word", {16'h0000, exp}, {16'h0000, st[31:16]});
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      logic [31:0] st;
      logic [9:0]  badCtl [3];
      badCtl = '{10'h118, 10'h144, 10'h159};
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      run(24'h00_104A, 17'h1_00AB, 10'h000, st);
      check("latch entry", 32'h0025_00AB, {10'h000, seenLatch});
      $display("test latch done");
      run(24'h80_1235, 17'h0_0000, 10'h158, st);
      check("erase status", 32'h0000_0002, {29'h0000_0000, st[2:0]});
      check("erase pulses", 32'h0000_0001, nErase);
      check("erase address", 32'h0000_1234, {8'h00, seenAdr});
      $display("test row erase done");
      run(24'h00_1040, 17'h0_0000, 10'h104, st);
      check("program status", 32'h0000_0002, {29'h0000_0000, st[2:0]});
      check("program pulses", 32'h0000_0001, nProg);
      check("program address", 32'h0000_1040, {8'h00, seenAdr});
      $display("test row program done");
      for (int i = 0; i < 3; i++) begin
         run(24'h00_1040, 17'h0_0000, badCtl[i], st);
         check("refused status", 32'h0000_0006, {29'h0000_0000, st[2:0]});
      end
      check("pulses after refusals", 32'h0000_0002, nErase + nProg);
      $display("test refusals done");
      eeOp(24'h7F_FE06, 17'h0_1234, 10'h104);
      eeOp(24'h7F_FE0A, 17'h0_BEEF, 10'h104);
      eeRead(24'h7F_FE06, 16'h1234);
      eeRead(24'h7F_FE0A, 16'hBEEF);
      eeOp(24'h7F_FE00, 17'h0_0000, 10'h159);
      eeRead(24'h7F_FE06, 16'hFFFF);
      eeRead(24'h7F_FE0A, 16'hBEEF);
      eeOp(24'h7F_FE00, 17'h0_0000, 10'h15A);
      eeRead(24'h7F_FE0A, 16'hFFFF);
      eeOp(24'h7F_FE0C, 17'h0_5A5A, 10'h104);
      eeRead(24'h7F_FE0C, 16'h5A5A);
      eeOp(24'h7F_FE0C, 17'h0_0000, 10'h158);
      eeRead(24'h7F_FE0C, 16'hFFFF);
      eeOp(24'h7F_FE02, 17'h0_0077, 10'h104);
      eeOp(24'h7F_FE00, 17'h0_0000, 10'h15F);
      eeRead(24'h7F_FE02, 16'hFFFF);
      $display("test eeprom done");
      end_of_test();
   end
endmodule
